// ---- core/dedc_apb_slv.sv ----
// APB slave handshake with one wait state and registered answers
`timescale 1ns/10ps
`default_nettype none
module dedc_apb_slv
  import dedc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] rd_word,
  input wire logic rd_fault,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic commit
);

  dedc_apb_e state_q, state_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;

  // First access cycle samples the answer; second completes it.
  // The wait state keeps every bus output straight off a flop.
  always_comb begin
    state_d = state_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    unique case (state_q)
      APB_IDLE: begin
        if (psel && penable) begin
          state_d = APB_ANSWER;
          prdata_d = rd_word;
          pslverr_d = rd_fault;
        end
      end
      APB_ANSWER: begin
        state_d = APB_IDLE;
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= APB_IDLE;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = (state_q == APB_ANSWER);
  // Transfer completes at this edge; writes take effect only here
  assign commit = (state_q == APB_ANSWER) && psel && penable;

endmodule
`default_nettype wire

// ---- core/dedc_pkg.sv ----
// Package: register map, field layout, status codes and carriers
package dedc_pkg;

  // Register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_ENABLE = 12'h004;
  localparam logic [11:0] OFS_CLEAR = 12'h008;
  localparam logic [11:0] OFS_DETAIL = 12'h00c;

  // Event bit positions, shared by status, enable and clear
  localparam int BIT_BUS = 0;
  localparam int BIT_REQ = 2;
  localparam int BIT_MAP = 3;
  localparam logic [3:0] EVT_MASK = 4'hd;
  localparam logic [3:0] EVT_RESET = 4'h0;

  // Detail word field positions
  localparam int DET_CHAIN = 17;
  localparam int DET_IRQ = 16;
  localparam int DET_TCC_LSB = 8;
  localparam int DET_CODE_LSB = 0;
  localparam logic [31:0] DET_RESET = 32'h0000_0000;

  // Transaction status codes
  localparam logic [3:0] ST_NONE = 4'h0;
  localparam logic [3:0] ST_RD_ADDR = 4'h1;
  localparam logic [3:0] ST_RD_PRIV = 4'h2;
  localparam logic [3:0] ST_RD_TMO = 4'h3;
  localparam logic [3:0] ST_RD_DATA = 4'h4;
  localparam logic [3:0] ST_RD_EXCL = 4'h7;
  localparam logic [3:0] ST_WR_ADDR = 4'h9;
  localparam logic [3:0] ST_WR_PRIV = 4'ha;
  localparam logic [3:0] ST_WR_TMO = 4'hb;
  localparam logic [3:0] ST_WR_DATA = 4'hc;
  localparam logic [3:0] ST_WR_EXCL = 4'hf;
  localparam int ST_WR_BIT = 3;

  // Status and option bits of one returned transaction
  typedef struct packed {
    logic [3:0] code;
    logic chain;
    logic irq;
    logic [5:0] completion_code;
  } dedc_txn_s;

  localparam dedc_txn_s TXN_RESET = '{code: 4'h0, chain: 1'b0,
                                      irq: 1'b0, completion_code: 6'h00};

  // Bus slave handshake states
  typedef enum logic {APB_IDLE, APB_ANSWER} dedc_apb_e;

  // Code comes from the write side of the map
  function automatic logic code_is_write(logic [3:0] code);
    return code[ST_WR_BIT];
  endfunction

  // Layout of the detail word; reserved bits forced low
  function automatic logic [31:0] det_pack(dedc_txn_s t);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[DET_CHAIN] = t.chain;
    w[DET_IRQ] = t.irq;
    w[DET_TCC_LSB +: 6] = t.completion_code;
    w[DET_CODE_LSB +: 4] = t.code;
    return w;
  endfunction

endpackage

// ---- core/dedc_stat_arb.sv ----
// Same-cycle arbiter between read and write status returns
`timescale 1ns/10ps
`default_nettype none
module dedc_stat_arb
  import dedc_pkg::*;
(
  input wire dedc_txn_s rd_txn,
  input wire dedc_txn_s wr_txn,
  output dedc_txn_s win_txn,
  output logic win_valid
);

  logic rd_err;
  logic wr_err;

  // Nonzero code marks a failure; write wins a tie
  always_comb begin
    rd_err = (rd_txn.code != ST_NONE);
    wr_err = (wr_txn.code != ST_NONE);
    win_valid = rd_err | wr_err;
    if (wr_err) begin // R6
      win_txn = wr_txn;
    end else if (rd_err) begin // R5
      win_txn = rd_txn;
    end else begin
      win_txn = TXN_RESET;
    end
  end

endmodule
`default_nettype wire

// ---- core/dedc_top.sv ----
// Error detail capture with status, enable, clear and APB access
//
// Functional notes
// R1: A failing transaction's chaining option bit is logged in bit 17.
// R2: Its completion-interrupt option bit is logged in bit 16.
// R3: Its six-bit completion code is logged in bits 13 to 8.
// R4: The nonzero four-bit status code is logged in bits 3 to 0.
// R5: With both statuses in one cycle and one nonzero, that one is taken.
// R6: With both nonzero in one cycle, the write status is taken.
// R7: Read failures use codes 1, 2, 3, 4 and 7; 5 and 6 are reserved.
// R8: Write failures use codes 9, a, b, c and f; 8, d and e are reserved.
// R9: The detail word is read-only, resets to zero, reserved bits read 0.
// R10: Clearing the bus fault flag also wipes the detail word.
// R11: Clearing the other fault flags leaves the detail word alone.
// R12: A failed transfer sets the bus fault flag and fills the detail.
// R13: All detail fields are loaded together in one cycle.
`timescale 1ns/10ps
`default_nettype none
module dedc_top
  import dedc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dedc_txn_s rd_txn,
  input wire dedc_txn_s wr_txn,
  input wire logic req_fault_evt,
  output logic err_irq
);

  dedc_txn_s win_txn;
  logic win_valid;
  logic commit;
  logic [31:0] rd_word;
  logic rd_fault;

  // Register state
  dedc_txn_s det_q, det_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] en_q, en_d;
  logic irq_q, irq_d;

  // Decoded write strobes
  logic wr_en_reg;
  logic wr_clr_reg;
  logic [3:0] clr_bits;
  logic map_fault;

  dedc_stat_arb u_arb (
    .rd_txn(rd_txn),
    .wr_txn(wr_txn),
    .win_txn(win_txn),
    .win_valid(win_valid)
  );

  dedc_apb_slv u_apb (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .rd_word(rd_word),
    .rd_fault(rd_fault),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .commit(commit)
  );

  // Read mux; unmapped offsets answer zero with pslverr
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_fault = 1'b0;
    unique case (paddr)
      OFS_STATUS: rd_word = {28'h0000000, stat_q};
      OFS_ENABLE: rd_word = {28'h0000000, en_q};
      OFS_CLEAR: rd_word = 32'h0000_0000;
      OFS_DETAIL: rd_word = det_pack(det_q); // R9
      default: rd_fault = 1'b1;
    endcase
  end

  // Write decode; only the low byte lane holds live bits.
  // Writes to the detail offset are accepted and ignored.
  always_comb begin
    wr_en_reg = commit && pwrite && pstrb[0] && (paddr == OFS_ENABLE);
    wr_clr_reg = commit && pwrite && pstrb[0] && (paddr == OFS_CLEAR);
    clr_bits = wr_clr_reg ? (pwdata[3:0] & EVT_MASK) : 4'h0;
    map_fault = commit && rd_fault;
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    stat_d = stat_q & ~clr_bits;
    if (win_valid) begin
      stat_d[BIT_BUS] = 1'b1; // R12
    end
    if (req_fault_evt) begin
      stat_d[BIT_REQ] = 1'b1;
    end
    if (map_fault) begin
      stat_d[BIT_MAP] = 1'b1;
    end
    en_d = wr_en_reg ? (pwdata[3:0] & EVT_MASK) : en_q;
    irq_d = |(stat_d & en_d);
  end

  // Detail capture: the latest failure overwrites as one word.
  // Clearing the bus flag wipes it, but a fresh error still lands.
  always_comb begin
    det_d = det_q;
    if (win_valid) begin
      det_d = win_txn; // R1 R2 R3 R4 R7 R8 R12 R13
    end else if (clr_bits[BIT_BUS]) begin // R11
      det_d = TXN_RESET; // R10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      det_q <= TXN_RESET; // R9
      stat_q <= EVT_RESET;
      en_q <= EVT_RESET;
      irq_q <= 1'b0;
    end else begin
      det_q <= det_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  assign err_irq = irq_q;

  // Checks on capture, arbitration, clearing, interrupt level and answer timing
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic rd_nz;
  logic wr_nz;
  logic det_wr;
  assign rd_nz = (rd_txn.code != ST_NONE);
  assign wr_nz = (wr_txn.code != ST_NONE);
  assign det_wr = commit && pwrite && (paddr == OFS_DETAIL);

  sequence s_bus_clear;
    wr_clr_reg && pwdata[BIT_BUS] && !win_valid;
  endsequence

  sequence s_other_clear;
    wr_clr_reg && !pwdata[BIT_BUS] && (pwdata[3:0] != 4'h0) && !win_valid;
  endsequence

  chk_chain_capture: assert property ( // R1
    win_valid |=> det_q.chain == $past(win_txn.chain))
    else $error("chain flag not logged");

  chk_irq_capture: assert property ( // R2
    win_valid |=> det_q.irq == $past(win_txn.irq))
    else $error("completion irq flag not logged");

  chk_tcc_capture: assert property ( // R3
    win_valid |=> det_q.completion_code == $past(win_txn.completion_code))
    else $error("completion code not logged");

  chk_code_nonzero: assert property ( // R4
    win_valid |=> det_q.code != ST_NONE)
    else $error("logged status code is zero");

  chk_single_pick: assert property ( // R5
    (rd_nz && !wr_nz) |=> det_q == $past(rd_txn))
    else $error("lone read status not taken");

  chk_write_wins: assert property ( // R6
    (rd_nz && wr_nz) |=> det_q == $past(wr_txn))
    else $error("write status lost the tie");

  chk_read_class: assert property ( // R7
    (rd_nz && !wr_nz && !code_is_write(rd_txn.code))
      |=> !code_is_write(det_q.code))
    else $error("read failure logged as write class");

  chk_write_class: assert property ( // R8
    (wr_nz && code_is_write(wr_txn.code)) |=> code_is_write(det_q.code))
    else $error("write failure logged as read class");

  chk_detail_ro: assert property ( // R9
    (det_wr && !win_valid) |=> $stable(det_q))
    else $error("software write changed detail");

  chk_reserved_zero: assert property ( // R9
    (pready && paddr == OFS_DETAIL && !pwrite)
      |-> (prdata[31:18] == 14'h0000) && (prdata[15:14] == 2'h0)
          && (prdata[7:4] == 4'h0))
    else $error("detail reserved bits not zero");

  chk_bus_clear: assert property ( // R10
    s_bus_clear |=> (det_q == TXN_RESET) && !stat_q[BIT_BUS])
    else $error("bus clear did not wipe detail");

  chk_other_clear: assert property ( // R11
    s_other_clear |=> $stable(det_q))
    else $error("other clear touched detail");

  chk_bus_flag_set: assert property ( // R12
    win_valid |=> stat_q[BIT_BUS] [*1] ##0 (det_q.code != ST_NONE))
    else $error("bus fault flag not set");

  chk_atomic_load: assert property ( // R13
    win_valid |=> det_q == $past(win_txn))
    else $error("detail fields not loaded together");

  chk_irq_level: assert property (
    ##1 err_irq == |($past(stat_d) & $past(en_d)))
    else $error("interrupt level mismatch");

  chk_answer_once: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

  // Flag and mask register behaviour
  chk_bus_sticky: assert property ( // R12
    (stat_q[BIT_BUS] && !clr_bits[BIT_BUS]) |=> stat_q[BIT_BUS])
    else $error("bus fault flag dropped");

  chk_req_flag: assert property (
    req_fault_evt |=> stat_q[BIT_REQ])
    else $error("request fault flag not set");

  chk_map_flag: assert property (
    map_fault |=> stat_q[BIT_MAP])
    else $error("map fault flag not set");

  chk_status_gap: assert property (
    !stat_q[1] && !en_q[1])
    else $error("reserved flag bit set");

  chk_mask_write: assert property (
    wr_en_reg |=> en_q == ($past(pwdata[3:0]) & EVT_MASK))
    else $error("enable write not taken");

  chk_strobe_gate: assert property (
    (commit && pwrite && !pstrb[0]) |=> $stable(en_q))
    else $error("write without low strobe took effect");

  chk_irq_masked: assert property (
    (en_q == 4'h0 && !wr_en_reg) |=> !err_irq)
    else $error("interrupt raised while masked");

  // Detail word holds between failures and bus clears
  chk_detail_hold: assert property ( // R13
    (!win_valid && !clr_bits[BIT_BUS]) |=> $stable(det_q))
    else $error("detail changed with no failure");

  // A failure in the clear cycle must survive the clear
  chk_set_beats_clear: assert property ( // R10
    (win_valid && clr_bits[BIT_BUS])
      |=> stat_q[BIT_BUS] && (det_q == $past(win_txn)))
    else $error("clear beat a fresh failure");

  // Values seen straight after reset
  chk_reset_state: assert property ( // R9
    $fell(sys_rst)
      |-> (det_q == TXN_RESET) && (stat_q == EVT_RESET) && !err_irq)
    else $error("state not zero after reset");

  // Bus answers: error, read data and idle levels
  chk_slverr_map: assert property (
    (psel && penable && !pready && rd_fault) |=> pslverr)
    else $error("unmapped access not flagged");

  chk_slverr_quiet: assert property (
    !pready |-> !pslverr)
    else $error("error response outside answer");

  chk_prdata_quiet: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");

  chk_ready_gap: assert property (
    pready |=> !pready)
    else $error("ready held too long");

  chk_detail_read: assert property ( // R9
    (psel && penable && !pready && !pwrite && paddr == OFS_DETAIL)
      |=> (prdata[17:16] == $past({det_q.chain, det_q.irq}))
          && (prdata[13:8] == $past(det_q.completion_code))
          && (prdata[3:0] == $past(det_q.code)))
    else $error("detail read fields wrong");

  chk_status_read: assert property (
    (psel && penable && !pready && !pwrite && paddr == OFS_STATUS)
      |=> prdata == {28'h0000000, $past(stat_q)})
    else $error("status read wrong");

  chk_clear_reads_zero: assert property (
    (psel && penable && !pready && !pwrite && paddr == OFS_CLEAR)
      |=> prdata == 32'h0000_0000)
    else $error("clear offset read not zero");

endmodule
`default_nettype wire

// ---- verification/dedc_stat_src.sv ----
// Model of the bus endpoints returning read and write status
`timescale 1ns/10ps
`default_nettype none
module dedc_stat_src
  import dedc_pkg::*;
(
  input wire logic sys_clk,
  output dedc_txn_s rd_txn,
  output dedc_txn_s wr_txn
);
  // Quiet returns start at zero
  initial begin
    rd_txn = TXN_RESET;
    wr_txn = TXN_RESET;
  end
  // One return per call, one cycle wide; idle code is zero
  // Option bits are flipped when idle so stale values never pass
  task automatic send(input dedc_txn_s rd, input dedc_txn_s wr);
    @(posedge sys_clk);
    rd_txn <= rd;
    wr_txn <= wr;
    @(posedge sys_clk);
    rd_txn <= {4'h0, ~rd[7:0]};
    wr_txn <= {4'h0, ~wr[7:0]};
  endtask
endmodule
`default_nettype wire

// ---- verification/test_dma_error_detail_capture.sv ----
// Self-checking bench for the error detail capture block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module test_dma_error_detail_capture
  import dedc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic req_fault_evt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, err_irq, serr;
  dedc_txn_s rd_txn, wr_txn;
  int n_errors = 0;
  int checks = 0;

  dedc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rd_txn(rd_txn), .wr_txn(wr_txn), .req_fault_evt(req_fault_evt),
    .err_irq(err_irq));

  dedc_stat_src src (.sys_clk(sys_clk), .rd_txn(rd_txn), .wr_txn(wr_txn));

  // 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;

  // Expected detail word, built field by field
  function automatic logic [31:0] det_exp(dedc_txn_s t);
    return {14'h0, t.chain, t.irq, 2'h0, t.completion_code, 4'h0, t.code};
  endfunction

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) n_errors++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask

  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 200 cycles the tests need
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    wrap_up;
  end

  // Main sequence
  initial begin
    dedc_txn_s t;
    dedc_txn_s z;
    z = TXN_RESET;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(OFS_DETAIL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    // Every documented code, other bus quiet in the same cycle
    for (int i = 0; i < 10; i++) begin
      t.code = (i < 5) ? 4'(i + 1) : 4'(i + 4);
      t.code = (i == 4) ? 4'h7 : t.code;
      t.code = (i == 5) ? 4'h9 : (i == 9) ? 4'hf : t.code;
      t.chain = i[0];
      t.irq = i[1];
      t.completion_code = 6'(i * 7);
      if (t.code[3]) src.send(z, t);
      else src.send(t, z);
      rd(OFS_DETAIL, det_exp(t));
      rd(OFS_STATUS, 32'h1);
    end
    // Both buses fail together: write side wins
    t = '{code: 4'hb, chain: 1'b1, irq: 1'b0, completion_code: 6'h2a};
    src.send('{code: 4'h4, chain: 1'b0, irq: 1'b1, completion_code: 6'h15}, t);
    rd(OFS_DETAIL, det_exp(t));
    // Detail word ignores writes
    apb(1'b1, OFS_DETAIL, 32'hffffffff);
    rd(OFS_DETAIL, det_exp(t));
    // Map and request faults, then clear them
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK(serr, 1'b1)
    @(posedge sys_clk) req_fault_evt <= 1'b1;
    @(posedge sys_clk) req_fault_evt <= 1'b0;
    rd(OFS_STATUS, 32'hd);
    apb(1'b1, OFS_CLEAR, 32'hc);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_DETAIL, det_exp(t));
    // Write with the low lane strobe off is ignored
    pstrb <= 4'he;
    apb(1'b1, OFS_ENABLE, 32'h1);
    pstrb <= 4'hf;
    rd(OFS_ENABLE, 32'h0);
    // Interrupt raised, masked, raised again, then cleared
    apb(1'b1, OFS_ENABLE, 32'h1);
    rd(OFS_ENABLE, 32'h1);
    `CHK(err_irq, 1'b1)
    apb(1'b1, OFS_ENABLE, 32'h0);
    rd(OFS_ENABLE, 32'h0);
    `CHK(err_irq, 1'b0)
    apb(1'b1, OFS_ENABLE, 32'h1);
    apb(1'b1, OFS_CLEAR, 32'h1);
    rd(OFS_STATUS, 32'h0);
    `CHK(err_irq, 1'b0)
    rd(OFS_DETAIL, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
